//--- common/reset_seq_pkg.sv
// Types shared by the reset sequencer
package reset_seq_pkg;
  typedef enum {
    ST_POR,
    ST_BROWN,
    ST_DELAY,
    ST_START,
    ST_HOLD,
    ST_RUN
  } seq_state_e;
  typedef logic [1:0] osc_mode_t;
  localparam osc_mode_t OSC_CRYSTAL = 2'h0;
  localparam osc_mode_t OSC_RC = 2'h1;
  localparam osc_mode_t OSC_EXTCLK = 2'h2;
  localparam osc_mode_t OSC_INTERNAL = 2'h3;
endpackage

//--- common/reset_seq_regs.svh
// Register offsets, field positions, reset values and timing counts of the reset sequencer
`ifndef RESET_SEQ_REGS_SVH
`define RESET_SEQ_REGS_SVH
`define PWRCTL_OFFSET 8'h8e
`define STATUS_OFFSET 8'h03
`define PWRCTL_BROWN_BIT 0
`define PWRCTL_POR_BIT 1
`define STATUS_SLEEP_BIT 3
`define STATUS_WDOG_BIT 4
`define STATUS_POR_VALUE 8'h18
`define STATUS_KEEP_MASK 8'h07
`define PWRUP_DELAY_MS 64
`define REF_CLK_HZ 50000000
`define PWRUP_CYCLES ((`PWRUP_DELAY_MS * (`REF_CLK_HZ / 1000)))
`define START_PERIODS 1024
`define RC_DIV 2
`define DIP_MIN_CYCLES 16
`endif

//--- rtl/reset_timeout_sequencer.sv
// Reset sequencer: power-up timer, brown-out filter, start-up count, reset-cause flags
//
// Summary of operation
// - 64 ms delay only after power-on or brown-out
// - Power-up timer ticks on RC oscillator enable
// - Internal reset held while power-up timer counts
// - Disable bit set skips power-up timer
// - Mode 00 off, 10 off in sleep
// - Brown-out reset after dip longer than minimum
// - Reset held until supply good, then delay
// - Dip during delay restarts full delay
// - Start-up count after power-up timer ends, or straight away when the timer is disabled
// - Crystal mode adds 1024 oscillator periods
// - RC, external, internal: power-up delay only
// - Timeouts ignore master clear; release starts immediately
// - Power control register at 8Eh
// - Bit 0 cleared by brown-out, software sets
// - Bit 1 zero on power-on, software writes one
// - Timeout and powerdown flags encode reset cause
// - Status reset values per reset kind
// - Watchdog wake-up keeps register contents
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ns
`include "reset_seq_regs.svh"
module reset_timeout_sequencer
  import reset_seq_pkg::*;
#(
  parameter int PWRUP_CYCLES = `PWRUP_CYCLES,
  parameter int START_PERIODS = `START_PERIODS,
  parameter int RC_DIV = `RC_DIV,
  parameter int DIP_MIN_CYCLES = `DIP_MIN_CYCLES
) (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic MASTER_CLEAR_N,
  input wire logic SUPPLY_LOW,
  input wire logic OSC_CLK_TICK,
  input wire logic POWER_UP_TIMER_DISABLE,
  input wire logic [1:0] BROWN_OUT_MODE_SELECT,
  input wire logic [1:0] OSC_MODE,
  input wire logic SLEEPING,
  input wire logic WDT_TIMEOUT,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  output logic CHIP_RESET,
  output logic WAKE_UP
);

  // RC and dip counters are 16 bits wide; the delay needs at least one RC tick
  if (PWRUP_CYCLES < 1 || PWRUP_CYCLES < RC_DIV || START_PERIODS < 1 || RC_DIV < 1
      || RC_DIV > 65536 || DIP_MIN_CYCLES < 1 || DIP_MIN_CYCLES > 65535) begin : g_bad_counts
    $error("Counts out of the range the counters serve");
  end

  // ==========================================================================
  // Input synchronisers
  logic [1:0] clr_s, low_s, osc_s;
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      clr_s <= 2'h0;
      low_s <= 2'h3;
      osc_s <= 2'h0;
    end else begin
      clr_s <= {clr_s[0], MASTER_CLEAR_N};
      low_s <= {low_s[0], SUPPLY_LOW};
      osc_s <= {osc_s[0], OSC_CLK_TICK};
    end
  end
  wire clr_n = clr_s[1];
  wire osc_lvl = osc_s[1];
  logic osc_prev_q;
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) osc_prev_q <= 1'b0;
    else osc_prev_q <= osc_lvl;
  end
  wire osc_edge = osc_lvl & ~osc_prev_q;

  // ==========================================================================
  // RC oscillator enable; stands in for the internal RC source
  logic [15:0] rc_cnt_q;
  wire rc_tick = (rc_cnt_q == 16'(RC_DIV - 1));
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) rc_cnt_q <= 16'h0;
    else if (rc_tick) rc_cnt_q <= 16'h0;
    else rc_cnt_q <= rc_cnt_q + 16'h1;
  end

  // ==========================================================================
  // Brown-out detection
  // Mode 10 gates detection in sleep, mode 00 never detects
  wire brown_active = (BROWN_OUT_MODE_SELECT == 2'h3) || (BROWN_OUT_MODE_SELECT == 2'h1)
                 || (BROWN_OUT_MODE_SELECT == 2'h2 && !SLEEPING);
  logic [15:0] dip_cnt_q;
  logic brown_q;
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      dip_cnt_q <= 16'h0;
    end else if (!low_s[1] || !brown_active) begin
      dip_cnt_q <= 16'h0;
    end else if (dip_cnt_q != 16'(DIP_MIN_CYCLES)) begin
      dip_cnt_q <= dip_cnt_q + 16'h1; // Short dips never reach the limit
    end
  end
  wire brown_evt = (dip_cnt_q == 16'(DIP_MIN_CYCLES)) && low_s[1] && brown_active;

  // ==========================================================================
  // Time-out sequence
  seq_state_e state_q;
  logic [31:0] cnt_q;
  logic sleep_wake_q;
  wire crystal = (OSC_MODE == OSC_CRYSTAL);
  wire wake_req = SLEEPING && state_q == ST_RUN && WDT_TIMEOUT;
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_q <= ST_POR;
      cnt_q <= 32'h0;
    end else if (brown_evt) begin
      state_q <= ST_BROWN; // Re-entry restarts whole delay
      cnt_q <= 32'h0;
    end else begin
      unique case (state_q)
        ST_POR, ST_BROWN: begin
          // Held until supply above threshold
          if (!low_s[1]) begin
            cnt_q <= 32'h0;
            if (!POWER_UP_TIMER_DISABLE) state_q <= ST_DELAY;
            else if (crystal) state_q <= ST_START;
            else state_q <= ST_HOLD; // No time-out at all
          end
        end
        ST_DELAY: begin
          if (rc_tick) begin
            if (cnt_q == 32'(PWRUP_CYCLES / RC_DIV) - 32'h1) begin
              cnt_q <= 32'h0;
              state_q <= crystal ? ST_START : ST_HOLD;
            end else begin
              cnt_q <= cnt_q + 32'h1;
            end
          end
        end
        ST_START: begin
          if (osc_edge) begin
            if (cnt_q == 32'(START_PERIODS - 1)) begin
              cnt_q <= 32'h0;
              state_q <= ST_HOLD;
            end else begin
              cnt_q <= cnt_q + 32'h1;
            end
          end
        end
        ST_HOLD: begin
          if (clr_n) state_q <= ST_RUN; // Timeouts done, release runs at once
        end
        ST_RUN: begin
          if (!clr_n) state_q <= ST_HOLD; // Master clear: no delay
          else if (wake_req && crystal) begin
            state_q <= ST_START; // Wake-up count only
            cnt_q <= 32'h0;
          end
        end
      endcase
    end
  end

  // Sleep wake-up: core not reset, only the start-up count stalls it
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) sleep_wake_q <= 1'b0;
    else if (wake_req) sleep_wake_q <= 1'b1;
    else if (state_q != ST_START) sleep_wake_q <= 1'b0;
  end

  // Reset held through delay and start-up count, except the start-up count after a sleep wake-up
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      CHIP_RESET <= 1'b1;
      WAKE_UP <= 1'b0;
    end else begin
      CHIP_RESET <= !(state_q == ST_RUN) && !sleep_wake_q;
      WAKE_UP <= wake_req;
    end
  end

  // ==========================================================================
  // Reset-cause flags
  logic por_n_q, brown_n_q, timeout_n_q, sleep_n_q;
  logic [2:0] status_lo_q;
  logic clr_prev_q;
  wire clr_fall = clr_prev_q && !clr_n && state_q == ST_RUN;
  wire wr_pwr = WR && ADDR == `PWRCTL_OFFSET;
  wire wr_sts = WR && ADDR == `STATUS_OFFSET;
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) clr_prev_q <= 1'b0;
    else clr_prev_q <= clr_n;
  end
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      por_n_q <= 1'b0;
      brown_n_q <= 1'b0;
    end else if (brown_evt) begin
      brown_n_q <= 1'b0; // Brown-out clear beats a software write
    end else if (wr_pwr) begin
      por_n_q <= WDATA[`PWRCTL_POR_BIT];
      brown_n_q <= WDATA[`PWRCTL_BROWN_BIT];
    end
  end
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      timeout_n_q <= 1'b1;
      sleep_n_q <= 1'b1;
    end else if (brown_evt) begin
      timeout_n_q <= 1'b1;
      sleep_n_q <= 1'b1;
    end else if (WDT_TIMEOUT && state_q == ST_RUN) begin
      timeout_n_q <= 1'b0; // Wake-up clears both, run reset only timeout
      sleep_n_q <= SLEEPING ? 1'b0 : sleep_n_q;
    end else if (clr_fall && SLEEPING) begin
      timeout_n_q <= 1'b1;
      sleep_n_q <= 1'b0;
    end
  end
  // Own process, so a watchdog or clear flag event never swallows a software write; a brown-out does
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) status_lo_q <= 3'((`STATUS_POR_VALUE) & (`STATUS_KEEP_MASK));
    else if (brown_evt) status_lo_q <= 3'h0;
    else if (wr_sts) status_lo_q <= WDATA[2:0]; // Bits 2:0 are written by software; the timeout and powerdown flags stay read-only
  end

  // ==========================================================================
  // Register reads, one cycle after the strobe
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      RDATA <= 8'h0;
    end else if (RD && ADDR == `PWRCTL_OFFSET) begin
      RDATA <= {6'h0, por_n_q, brown_n_q};
    end else if (RD && ADDR == `STATUS_OFFSET) begin
      RDATA <= {3'h0, timeout_n_q, sleep_n_q, status_lo_q};
    end else begin
      RDATA <= 8'h0;
    end
  end

endmodule

//--- tb/reset_timeout_sequencer_props.sv
// Port checker of the reset sequencer
`timescale 1ns/1ns
module seq_checker #(
  parameter int PWRUP_CYCLES = 64
) (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic MASTER_CLEAR_N,
  input wire logic SUPPLY_LOW,
  input wire logic POWER_UP_TIMER_DISABLE,
  input wire logic [1:0] BROWN_OUT_MODE_SELECT,
  input wire logic [7:0] ADDR,
  input wire logic RD,
  input wire logic [7:0] RDATA,
  input wire logic CHIP_RESET,
  input wire logic WAKE_UP
);
  // ==========
  // Cycles of good supply, since the delay restarts on any dip longer than the minimum while brown-out detection is on
  int good_cnt;
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) good_cnt <= 0;
    else good_cnt <= SUPPLY_LOW ? 0 : good_cnt + 1;
  end
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  power_up_timer_length_a: assert property ($fell(CHIP_RESET) && !POWER_UP_TIMER_DISABLE
    |-> good_cnt >= PWRUP_CYCLES) else $error("reset released before full delay");
  clear_holds_a: assert property (!MASTER_CLEAR_N [*5] |-> CHIP_RESET)
    else $error("master clear ignored");
  brown_out_a: assert property ((SUPPLY_LOW && BROWN_OUT_MODE_SELECT == 2'h1) [*8]
    |-> ##3 CHIP_RESET) else $error("long dip gave no reset");
  supply_good_a: assert property ($fell(CHIP_RESET) |-> !$past(SUPPLY_LOW, 5))
    else $error("reset released on low supply");
  read_idle_a: assert property (!$past(RD) |-> RDATA == 8'h00)
    else $error("read data outside read slot");
  pwrctl_bits_a: assert property ($past(RD) && $past(ADDR) == 8'h8e |-> RDATA[7:2] == 6'h00)
    else $error("power control upper bits set");
  status_top_a: assert property ($past(RD) && $past(ADDR) == 8'h03 |-> RDATA[7:5] == 3'h0)
    else $error("status upper bits set");
  wake_pulse_a: assert property (WAKE_UP |=> !WAKE_UP)
    else $error("wake pulse too long");
  wake_keeps_a: assert property (WAKE_UP |=> !CHIP_RESET [*8])
    else $error("wake-up reset the core");
  cover property ($fell(CHIP_RESET));
  cover property (WAKE_UP);
  cover property (RD && ADDR == 8'h8e);
endmodule
bind reset_timeout_sequencer seq_checker #(.PWRUP_CYCLES(PWRUP_CYCLES)) i_seq_checker (.REF_CLK,
  .RST_N, .MASTER_CLEAR_N, .SUPPLY_LOW, .POWER_UP_TIMER_DISABLE, .BROWN_OUT_MODE_SELECT,
  .ADDR, .RD, .RDATA, .CHIP_RESET, .WAKE_UP);

//--- tb/supply_pin_model.sv
// Model of the clear pin, supply comparator and crystal
`timescale 1ns/1ns
module supply_pin_model (
  input wire logic clk,
  input wire logic dip,
  input wire logic hold,
  output logic supply_low,
  output logic master_clear_n,
  output logic osc_tick
);
  // ==========
  // Pin levels; pull-up gives high when nobody holds the pin
  assign supply_low = dip;
  assign master_clear_n = !hold;
  always_ff @(posedge clk) osc_tick <= (osc_tick === 1'b0);
endmodule

//--- tb/test_reset_timeout_sequencer.sv
// Self-checking bench of the reset sequencer
`timescale 1ns/1ns
module test_reset_timeout_sequencer
  import reset_seq_pkg::*;
;
  logic clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, wdt = 1'b0, dip = 1'b0, slp = 1'b0;
  logic dis = 1'b0, hold = 1'b1, chip_reset, wake_up, supply_low, master_clear_n_n, osc_tick;
  logic [1:0] bmode = 2'h1;
  osc_mode_t omode = OSC_RC;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, v;
  int n_fail = 0, n_compared = 0, n;
  // ==========
  // Shortened counts keep the run brief
  reset_timeout_sequencer #(.PWRUP_CYCLES(64), .START_PERIODS(8), .RC_DIV(2), .DIP_MIN_CYCLES(4))
    i_reset_timeout_sequencer (.REF_CLK(clk), .RST_N(rst_n), .MASTER_CLEAR_N(master_clear_n_n),
    .SUPPLY_LOW(supply_low), .OSC_CLK_TICK(osc_tick), .POWER_UP_TIMER_DISABLE(dis),
    .BROWN_OUT_MODE_SELECT(bmode), .OSC_MODE(omode), .SLEEPING(slp), .WDT_TIMEOUT(wdt),
    .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .CHIP_RESET(chip_reset),
    .WAKE_UP(wake_up));
  supply_pin_model i_supply_pin_model (.clk(clk), .dip(dip), .hold(hold),
    .supply_low(supply_low), .master_clear_n(master_clear_n_n), .osc_tick(osc_tick));
  initial begin
    forever #10 clk = ~clk;
  end
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %0t saw %h expected %h", $time, seen, exp);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task run_wait;
    n = 0;
    while (chip_reset !== 1'b0 && n < 3000) begin
      @(posedge clk);
      #1 n++;
    end
    if (n >= 3000) chk(8'h00, 8'h01);
  endtask
  task power_up(input logic d, input osc_mode_t m, input int lo, input int hi);
    @(posedge clk);
    rst_n <= 1'b0;
    dis <= d;
    omode <= m;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    run_wait();
    chk({7'h0, n >= lo && n <= hi}, 8'h01);
  endtask
  task dip_for(input int c, input logic [1:0] m, input logic s);
    @(posedge clk);
    bmode <= m;
    slp <= s;
    dip <= 1'b1;
    repeat (c) @(posedge clk);
    dip <= 1'b0;
  endtask
  task watchdog(input logic s, input logic [7:0] exp);
    logic woke, held;
    woke = 1'b0;
    held = 1'b0;
    @(posedge clk);
    slp <= s;
    wdt <= 1'b1;
    @(posedge clk);
    wdt <= 1'b0;
    repeat (20) begin
      #1 woke = woke | (wake_up === 1'b1);
      held = held | (chip_reset !== 1'b0);
      @(posedge clk);
    end
    slp <= 1'b0;
    run_wait();
    chk({7'h0, woke}, {7'h0, s});
    chk({7'h0, held}, 8'h00);
    bus(1'b0, 8'h03, 8'h00);
    chk(v & 8'h18, exp);
  endtask
  task tally_and_finish;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    bus(1'b0, 8'h8e, 8'h00);
    chk(v, 8'h00);
    bus(1'b0, 8'h03, 8'h00);
    chk(v, 8'h18);
    bus(1'b0, 8'h10, 8'h00);
    chk(v, 8'h00);
    repeat (150) @(posedge clk);
    hold <= 1'b0;
    run_wait();
    chk({7'h0, n < 6}, 8'h01);
    bus(1'b1, 8'h8e, 8'h03);
    dip_for(12, 2'h1, 1'b0);
    repeat (30) @(posedge clk);
    dip_for(12, 2'h1, 1'b0);
    run_wait();
    chk({7'h0, n >= 64}, 8'h01);
    bus(1'b0, 8'h8e, 8'h00);
    chk(v, 8'h02);
    dip_for(12, 2'h0, 1'b0);
    dip_for(12, 2'h2, 1'b1);
    #1 chk({7'h0, chip_reset}, 8'h00);
    dip_for(12, 2'h2, 1'b0);
    #1 chk({7'h0, chip_reset}, 8'h01);
    run_wait();
    chk({7'h0, n >= 64}, 8'h01);
    dip_for(12, 2'h3, 1'b0);
    #1 chk({7'h0, chip_reset}, 8'h01);
    run_wait();
    @(posedge clk);
    bmode <= 2'h1;
    hold <= 1'b1;
    repeat (10) @(posedge clk);
    hold <= 1'b0;
    #1 chk({7'h0, chip_reset}, 8'h01);
    run_wait();
    chk({7'h0, n < 6}, 8'h01);
    watchdog(1'b0, 8'h08);
    watchdog(1'b1, 8'h00);
    power_up(1'b0, OSC_RC, 64, 140);
    power_up(1'b1, OSC_RC, 0, 8);
    power_up(1'b1, OSC_CRYSTAL, 16, 40);
    power_up(1'b0, OSC_CRYSTAL, 80, 190);
    watchdog(1'b1, 8'h00);
    power_up(1'b1, OSC_EXTCLK, 0, 8);
    power_up(1'b0, OSC_INTERNAL, 64, 140);
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    tally_and_finish();
  end
endmodule
